// [asp_top.sv]
// async serial port: wishbone registers, baud generator, transmitter, receiver
// Overview of operation
// - frame is start, 8/9 data, one stop
// - both directions shift lsb first, 8/9 data width set per direction
// - baud tick x16 or x64 by speed bit
// - async only when clocked mode clear; sleep halts
// - shift register reloads only after stop bit
// - transfer empties buffer and sets empty flag
// - read-only shift register empty status bit
// - enabling transmit sets buffer empty flag
// - frame needs enable, buffered data, shift tick
// - clearing enable aborts frame, releases pin
// - ninth transmit bit captured at transfer
// - receive recovery at x16, shifter per bit
// - receive only with continuous receive enabled
// - stop bit moves word to fifo, sets ready
// - ready flag clears when fifo read empty
// - receive data is a two-entry fifo
// - full fifo at stop sets overrun, drops
// - overrun blocks transfers until receive re-enabled
// - framing error on low stop, queued per word
// - nine-bit receive stores ninth bit
// - three-sample majority vote per bit
`timescale 1ns/1ps
module asp_top (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // device state
    input  wire logic        sleep_i,
    // serial pins
    input  wire logic        rx_i,
    output logic             tx_o,
    output logic             tx_oe_o,
    // event lines
    output logic             tx_irq_o,
    output logic             rx_irq_o
);
    import asp_pkg::*;

    logic          ack_ff;
    logic [31:0]   dat_ff;
    logic [7:0]    tsc_ff;
    logic [7:0]    rsc_ff;
    logic [7:0]    brd_ff;
    logic [1:0]    ie_ff;
    logic [7:0]    txb_ff;
    logic          txb_full_ff;
    logic          txe_flag_ff;
    logic          transmit_enable_q_ff;
    logic          busy_ff;
    logic [10:0]   frame_ff;
    logic [3:0]    tbits_ff;
    logic [3:0]    tsub_ff;
    logic          tx_line_ff;
    logic          tx_oe_ff;
    logic [7:0]    brg_cnt_ff;
    logic [1:0]    pre_ff;
    asp_rx_state_t state_ff;
    logic [3:0]    rsub_ff;
    logic [3:0]    rbits_ff;
    logic [8:0]    rsr_ff;
    logic [1:0]    vote_ff;
    logic          rx_prev_ff;
    logic          overrun_error_ff;
    asp_rx_word_t  mem_ff [0:1];
    logic          wp_ff;
    logic          rp_ff;
    logic [1:0]    cnt_ff;

    // bus decode
    wire bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire wr      = bus_req & wb_we_i & wb_sel_i[0];
    wire rd      = bus_req & ~wb_we_i;
    wire hit_tsc = wb_adr_i == ASP_OFF_TSC;
    wire hit_rsc = wb_adr_i == ASP_OFF_RSC;
    wire hit_txb = wb_adr_i == ASP_OFF_TXB;
    wire hit_rxf = wb_adr_i == ASP_OFF_RXF;
    wire hit_brd = wb_adr_i == ASP_OFF_BRD;
    wire hit_evt = wb_adr_i == ASP_OFF_EVT;
    wire wr_txb  = wr & hit_txb;

    // control bits
    wire port_en  = rsc_ff[ASP_RSC_PORT_EN];
    wire nine_rx  = rsc_ff[ASP_RSC_NINE_RX];
    wire cont_rx  = rsc_ff[ASP_RSC_CONT_RX];
    wire nine_tx  = tsc_ff[ASP_TSC_NINE_TX];
    wire tx_en    = tsc_ff[ASP_TSC_TX_EN];
    wire clocked  = tsc_ff[ASP_TSC_CLOCKED];
    wire hi_speed = tsc_ff[ASP_TSC_HI_SPEED];
    wire tx_ninth = tsc_ff[ASP_TSC_TX_NINTH];
    wire async_on  = port_en & ~clocked & ~sleep_i;
    wire tx_active = async_on & tx_en;
    wire rx_active = async_on & cont_rx;

    // baud generator: counter held at divisor while idle
    wire brg_run   = tx_active | rx_active;
    wire brg_zero  = brg_cnt_ff == 8'h00;
    wire base_tick = brg_run & brg_zero;
    // low speed divides the x64 tick down to x16
    wire tick16 = base_tick & (hi_speed | (pre_ff == ASP_LOW_PRESCALE));

    // transmitter
    wire tx_shift = busy_ff & tick16 & (tsub_ff == ASP_BIT_LAST);
    wire tx_done  = tx_shift & (tbits_ff == 4'h1);
    // a load colliding with a buffer write waits one tick
    wire tx_load  = tx_active & tick16 & ~busy_ff & txb_full_ff & ~wr_txb;
    wire tx_ninth_out = nine_tx ? tx_ninth : 1'b1;
    wire [10:0] frame_new = {1'b1, tx_ninth_out, txb_ff, 1'b0};
    wire [3:0]  frame_len = nine_tx ? ASP_FRAME9 : ASP_FRAME8;
    wire txe_set = tx_load | (tx_en & ~transmit_enable_q_ff);

    // receiver
    wire maj = (vote_ff[1] & vote_ff[0]) | (vote_ff[1] & rx_i) | (vote_ff[0] & rx_i);
    wire in_idle    = state_ff == ASP_RX_IDLE;
    wire start_edge = tick16 & in_idle & rx_prev_ff & ~rx_i;
    wire vote_smp   = tick16 & ((rsub_ff == ASP_SMP_FIRST) | (rsub_ff == ASP_SMP_SECOND));
    wire decide     = tick16 & ~in_idle & (rsub_ff == ASP_SMP_DECIDE);
    wire at_stop    = decide & (state_ff == ASP_RX_STOP);
    wire [3:0] last_bit = nine_rx ? ASP_LAST9 : ASP_LAST8;
    wire pop   = rd & hit_rxf & (cnt_ff != 2'h0);
    wire room  = (cnt_ff != ASP_FIFO_DEPTH) | pop;
    wire push  = at_stop & ~overrun_error_ff & room;
    wire ovr   = at_stop & ~room;
    asp_rx_word_t word_in;
    assign word_in.framing_error  = ~maj;
    assign word_in.ninth = nine_rx & rsr_ff[8];
    assign word_in.data  = nine_rx ? rsr_ff[7:0] : rsr_ff[8:1];
    asp_rx_word_t head;
    assign head = mem_ff[rp_ff];
    wire rx_ready = cnt_ff != 2'h0;

    // read data
    wire [7:0] tsc_rd = tsc_ff | {6'h00, ~busy_ff, 1'b0};
    wire [7:0] rsc_rd = {rsc_ff[7:4], 1'b0, head.framing_error, overrun_error_ff, head.ninth};
    wire [7:0] evt_rd = {4'h0, ie_ff, rx_ready, txe_flag_ff};
    wire [7:0] rd_mux = hit_tsc ? tsc_rd :
                        hit_rsc ? rsc_rd :
                        hit_txb ? txb_ff :
                        hit_rxf ? head.data :
                        hit_brd ? brd_ff :
                        hit_evt ? evt_rd : 8'h00;

    assign wb_ack_o = ack_ff;
    assign wb_dat_o = dat_ff;
    assign tx_o     = tx_line_ff;
    assign tx_oe_o  = tx_oe_ff;
    assign tx_irq_o = txe_flag_ff & ie_ff[0];
    assign rx_irq_o = rx_ready & ie_ff[1];

    // bus slave: every access, mapped or not, is acked one cycle later
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_ff <= 1'b0;
            dat_ff <= 32'h0;
        end else begin
            ack_ff <= bus_req;
            if (rd) begin
                dat_ff <= {24'h0, rd_mux};
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tsc_ff <= ASP_TSC_RST & ASP_TSC_WMASK;
            rsc_ff <= ASP_RSC_RST;
            brd_ff <= ASP_BRD_RST;
            ie_ff  <= 2'h0;
            txb_ff <= ASP_TXB_RST;
        end else if (wr) begin
            if (hit_tsc) tsc_ff <= wb_dat_i[7:0] & ASP_TSC_WMASK;
            if (hit_rsc) rsc_ff <= wb_dat_i[7:0] & ASP_RSC_WMASK;
            if (hit_brd) brd_ff <= wb_dat_i[7:0];
            if (hit_evt) ie_ff <= wb_dat_i[ASP_EVT_RXR_IE:ASP_EVT_TXE_IE];
            if (hit_txb) txb_ff <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            brg_cnt_ff <= 8'h00;
            pre_ff     <= 2'h0;
        end else if (!brg_run) begin
            brg_cnt_ff <= brd_ff;
            pre_ff     <= 2'h0;
        end else begin
            brg_cnt_ff <= brg_zero ? brd_ff : brg_cnt_ff - 8'h01;
            if (base_tick) pre_ff <= pre_ff + 2'h1;
        end
    end

    // transmit buffer and its empty flag; set wins over the write
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            txb_full_ff <= 1'b0;
            txe_flag_ff <= 1'b1;
            transmit_enable_q_ff   <= 1'b0;
        end else begin
            transmit_enable_q_ff   <= tx_en;
            txe_flag_ff <= txe_set | (txe_flag_ff & ~wr_txb);
            if (wr_txb) txb_full_ff <= 1'b1;
            else if (tx_load) txb_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            busy_ff  <= 1'b0;
            frame_ff <= 11'h7ff;
            tbits_ff <= 4'h0;
            tsub_ff  <= 4'h0;
        end else if (!tx_active) begin
            busy_ff <= 1'b0;
            tsub_ff <= 4'h0;
        end else if (tx_load) begin
            busy_ff  <= 1'b1;
            frame_ff <= frame_new;
            tbits_ff <= frame_len;
            tsub_ff  <= 4'h0;
        end else if (busy_ff && tick16) begin
            tsub_ff <= tsub_ff + 4'h1;
            if (tx_shift) begin
                frame_ff <= {1'b1, frame_ff[10:1]};
                tbits_ff <= tbits_ff - 4'h1;
            end
            if (tx_done) busy_ff <= 1'b0;
        end
    end

    // pin outputs registered; idle line is high, released when disabled
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            tx_line_ff <= 1'b1;
            tx_oe_ff   <= 1'b0;
        end else begin
            tx_line_ff <= ~busy_ff | frame_ff[0];
            tx_oe_ff   <= tx_active;
        end
    end

    // receive state machine; clearing receive enable resets it and overrun
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_ff   <= ASP_RX_IDLE;
            rsub_ff    <= 4'h0;
            rbits_ff   <= 4'h0;
            rsr_ff     <= 9'h000;
            vote_ff    <= 2'h3;
            rx_prev_ff <= 1'b1;
            overrun_error_ff    <= 1'b0;
        end else if (!rx_active) begin
            state_ff   <= ASP_RX_IDLE;
            rx_prev_ff <= 1'b1;
            overrun_error_ff    <= 1'b0;
        end else begin
            if (ovr) overrun_error_ff <= 1'b1;
            if (tick16) rx_prev_ff <= rx_i;
            if (vote_smp) vote_ff <= {vote_ff[0], rx_i};
            if (start_edge) begin
                state_ff <= ASP_RX_START;
                rsub_ff  <= 4'h1;
            end else if (tick16 && !in_idle) begin
                rsub_ff <= rsub_ff + 4'h1;
            end
            if (decide) begin
                unique case (state_ff)
                    ASP_RX_START: begin
                        state_ff <= maj ? ASP_RX_IDLE : ASP_RX_DATA;
                        rbits_ff <= 4'h0;
                    end
                    ASP_RX_DATA: begin
                        rsr_ff   <= {maj, rsr_ff[8:1]};
                        rbits_ff <= rbits_ff + 4'h1;
                        if (rbits_ff == last_bit) state_ff <= ASP_RX_STOP;
                    end
                    ASP_RX_STOP: state_ff <= ASP_RX_IDLE;
                    ASP_RX_IDLE: state_ff <= ASP_RX_IDLE;
                endcase
            end
        end
    end

    // two-entry receive fifo; status bits travel with each word
    generate
        for (genvar i = 0; i < 2; i++) begin : g_fifo
            always_ff @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    mem_ff[i] <= '0;
                end else if (push && (wp_ff == 1'(i))) begin
                    mem_ff[i] <= word_in;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wp_ff  <= 1'b0;
            rp_ff  <= 1'b0;
            cnt_ff <= 2'h0;
        end else begin
            if (push) wp_ff <= ~wp_ff;
            if (pop) rp_ff <= ~rp_ff;
            cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
        end
    end

    frame_len_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tx_load |=> busy_ff && tbits_ff == ($past(nine_tx) ? ASP_FRAME9 : ASP_FRAME8))
        else $error("frame length wrong at load");
    lsb_first_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tx_shift && tx_active && !tx_done |=> frame_ff[0] == $past(frame_ff[1]))
        else $error("transmit not lsb first");
    tick_rate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        base_tick && !hi_speed && pre_ff != ASP_LOW_PRESCALE |-> !tick16)
        else $error("low speed tick not divided");
    sleep_halt_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        sleep_i |-> !tick16 && !tx_load && !push)
        else $error("activity during sleep");
    buf_empty_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tx_load |=> txe_flag_ff && !txb_full_ff && busy_ff)
        else $error("transfer did not empty buffer");
    transmit_enable_flag_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(tx_en) |=> txe_flag_ff)
        else $error("enable did not set empty flag");
    tx_abort_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !tx_active |=> !busy_ff && !tx_oe_o)
        else $error("transmit not aborted");
    ninth_cap_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        tx_load && nine_tx |=> frame_ff[9] == $past(tx_ninth))
        else $error("ninth bit not captured");
    rx_ready_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        push |=> rx_ready)
        else $error("ready not set after push");
    fifo_depth_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        cnt_ff <= ASP_FIFO_DEPTH)
        else $error("fifo over depth");
    overrun_set_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        rx_active && ovr |=> overrun_error_ff && cnt_ff == ASP_FIFO_DEPTH)
        else $error("overrun not flagged");
    overrun_block_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        overrun_error_ff |-> !push)
        else $error("transfer while overrun");
    reload_wait_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        busy_ff && tx_active && !tx_done |=> busy_ff)
        else $error("shift register reloaded mid frame");
    txe_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        wr_txb && !txe_set |=> !txe_flag_ff && txb_full_ff)
        else $error("buffer write did not clear empty flag");
    idle_line_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !busy_ff |=> tx_o)
        else $error("transmit line not idle high");
    rx_gate_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !rx_active |=> in_idle && !overrun_error_ff)
        else $error("receiver active while disabled");
    ready_clear_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        pop && cnt_ff == 2'h1 && !push |=> !rx_ready)
        else $error("ready flag stuck after last read");
    fifo_store_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        push |=> mem_ff[~wp_ff] == $past(word_in))
        else $error("receive word not queued with status");
    baud_reload_a: assert property (@(posedge clk_i) disable iff (!rstn_i)
        brg_zero |=> brg_cnt_ff == $past(brd_ff))
        else $error("baud counter not reloaded");
endmodule : asp_top

// [asp_pkg.sv]
// constants, field layouts and types shared by the async serial port
package asp_pkg;
    // register byte offsets (word aligned)
    localparam logic [4:0] ASP_OFF_TSC = 5'h00;
    localparam logic [4:0] ASP_OFF_RSC = 5'h04;
    localparam logic [4:0] ASP_OFF_TXB = 5'h08;
    localparam logic [4:0] ASP_OFF_RXF = 5'h0c;
    localparam logic [4:0] ASP_OFF_BRD = 5'h10;
    localparam logic [4:0] ASP_OFF_EVT = 5'h14;
    // transmit_status_control fields
    localparam int ASP_TSC_NINE_TX  = 6;
    localparam int ASP_TSC_TX_EN    = 5;
    localparam int ASP_TSC_CLOCKED  = 4;
    localparam int ASP_TSC_HI_SPEED = 2;
    localparam int ASP_TSC_SR_EMPTY = 1;
    localparam int ASP_TSC_TX_NINTH = 0;
    localparam logic [7:0] ASP_TSC_WMASK = 8'hf5;
    localparam logic [7:0] ASP_TSC_RST   = 8'h02;
    // receive_status_control fields
    localparam int ASP_RSC_PORT_EN = 7;
    localparam int ASP_RSC_NINE_RX = 6;
    localparam int ASP_RSC_CONT_RX = 4;
    localparam logic [7:0] ASP_RSC_WMASK = 8'hf0;
    localparam logic [7:0] ASP_RSC_RST   = 8'h00;
    // event register fields
    localparam int ASP_EVT_TXE_IE = 2;
    localparam int ASP_EVT_RXR_IE = 3;
    localparam logic [7:0] ASP_TXB_RST = 8'h00;
    localparam logic [7:0] ASP_BRD_RST = 8'h00;
    // oversampling and frame timing, in x16 ticks and bits
    localparam logic [1:0] ASP_LOW_PRESCALE = 2'h3;
    localparam logic [3:0] ASP_SMP_FIRST = 4'h7;
    localparam logic [3:0] ASP_SMP_SECOND = 4'h8;
    localparam logic [3:0] ASP_SMP_DECIDE = 4'h9;
    localparam logic [3:0] ASP_BIT_LAST = 4'hf;
    localparam logic [3:0] ASP_FRAME8 = 4'ha;
    localparam logic [3:0] ASP_FRAME9 = 4'hb;
    localparam logic [3:0] ASP_LAST8 = 4'h7;
    localparam logic [3:0] ASP_LAST9 = 4'h8;
    localparam logic [1:0] ASP_FIFO_DEPTH = 2'h2;
    typedef struct packed {
        logic       framing_error;
        logic       ninth;
        logic [7:0] data;
    } asp_rx_word_t;
    typedef enum logic [1:0] {
        ASP_RX_IDLE,
        ASP_RX_START,
        ASP_RX_DATA,
        ASP_RX_STOP
    } asp_rx_state_t;
endpackage : asp_pkg

// [asp_peer.sv]
// remote serial peer: frame sender on the receive pin, frame monitor on the transmit pin
`timescale 1ns/1ps
module asp_peer (
    // clock
    input  wire logic clk_i,
    // pin from the port
    input  wire logic tx_i,
    input  wire logic tx_oe_i,
    input  wire logic nine_i,
    // pin to the port
    output logic      rx_o
);
    int         bit_clks = 16;
    logic [9:0] got_q[$];
    logic [8:0] w;
    logic       ok;
    logic       stp;

    initial rx_o = 1'b1;

    // start, lsb-first data, optional ninth, stop; a low stop gets one extra idle bit
    task automatic send(input logic [8:0] d, input logic nine, input logic stop);
        logic [10:0] f;
        f = nine ? {stop, d, 1'b0} : {1'b1, stop, d[7:0], 1'b0};
        for (int i = 0; i < (nine ? 11 : 10); i++) begin
            rx_o <= f[i];
            repeat (bit_clks) @(posedge clk_i);
        end
        if (!stop) begin
            rx_o <= 1'b1;
            repeat (bit_clks) @(posedge clk_i);
        end
    endtask : send

    // samples mid-bit; a frame during which the pin was released is dropped
    initial forever begin
        @(posedge clk_i);
        if (tx_oe_i && !tx_i) begin
            ok = 1'b1;
            w = 9'h000;
            stp = 1'b0;
            repeat (bit_clks / 2) @(posedge clk_i);
            for (int i = 0; i < (nine_i ? 10 : 9); i++) begin
                repeat (bit_clks) @(posedge clk_i);
                ok = ok & tx_oe_i;
                if (i < (nine_i ? 9 : 8)) w[i] = tx_i;
                else stp = tx_i;
            end
            if (ok) got_q.push_back({stp, w});
        end
    end
endmodule : asp_peer

// [tb_top.sv]
// self-checking bench for the async serial port
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
    import asp_pkg::*;
    logic        clk_i, rstn_i, wb_cyc, wb_stb, wb_we, sleep, nine_sel;
    logic [4:0]  wb_adr;
    logic [31:0] wb_dat, wb_dat_o;
    logic        wb_ack_o, rx_line, tx_o, tx_oe_o, tx_irq_o, rx_irq_o;
    logic [7:0]  rq;
    logic [3:0]  wb_sel, sel_v;
    int          n_fail = 0;
    int          checks = 0;
    // released pin floats high through its pull-up
    wire         tx_pin = tx_oe_o ? tx_o : 1'b1;

    asp_top uut (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
                 .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
                 .wb_ack_o(wb_ack_o), .sleep_i(sleep), .rx_i(rx_line), .tx_o(tx_o), .tx_oe_o(tx_oe_o),
                 .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o));
    asp_peer peer (.clk_i(clk_i), .tx_i(tx_pin), .tx_oe_i(tx_oe_o), .nine_i(nine_sel), .rx_o(rx_line));

    always #2.5 clk_i = ~clk_i;

    // classic cycle: hold until ack is seen, then drop for one cycle
    task automatic wb(input logic [4:0] a, input logic we, input logic [7:0] d);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_sel <= sel_v;
        wb_adr <= a;
        wb_dat <= {24'h000000, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rq = wb_dat_o[7:0];
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
        wb_sel <= 4'h0;
        @(posedge clk_i);
    endtask : wb

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        wb(a, 1'b1, d);
    endtask : wr

    task automatic rd_chk(input logic [4:0] a, input logic [7:0] e);
        wb(a, 1'b0, 8'h00);
        `CHK(rq, e)
    endtask : rd_chk

    task automatic exp_frame(input logic [9:0] e);
        logic [9:0] g;
        g = 10'h000;
        for (int i = 0; i < 3000 && peer.got_q.size() == 0; i++) @(posedge clk_i);
        if (peer.got_q.size() != 0) g = peer.got_q.pop_front();
        `CHK(g, e)
    endtask : exp_frame

    task automatic t_reset;
        rd_chk(ASP_OFF_TSC, 8'h02);
        rd_chk(ASP_OFF_RSC, 8'h00);
        rd_chk(ASP_OFF_TXB, 8'h00);
        rd_chk(ASP_OFF_BRD, 8'h00);
        rd_chk(ASP_OFF_EVT, 8'h01);
        rd_chk(5'h18, 8'h00);
        `CHK(tx_oe_o, 1'b0)
        // a write without the low byte lane selected must be ignored
        sel_v = 4'h2;
        wr(ASP_OFF_BRD, 8'h55);
        sel_v = 4'hf;
        rd_chk(ASP_OFF_BRD, 8'h00);
    endtask : t_reset

    // write before enable, then a second word while the first is shifting
    task automatic t_tx_basic;
        wr(ASP_OFF_RSC, 8'h80);
        wr(ASP_OFF_TXB, 8'ha5);
        rd_chk(ASP_OFF_EVT, 8'h00);
        wr(ASP_OFF_TSC, 8'h24);
        rd_chk(ASP_OFF_EVT, 8'h01);
        rd_chk(ASP_OFF_TSC, 8'h24);
        wr(ASP_OFF_TXB, 8'h3c);
        wr(ASP_OFF_EVT, 8'h04);
        `CHK(tx_irq_o, 1'b0)
        exp_frame(10'h2a5);
        exp_frame(10'h23c);
        `CHK(tx_irq_o, 1'b1)
        repeat (16) @(posedge clk_i);
        rd_chk(ASP_OFF_TSC, 8'h26);
    endtask : t_tx_basic

    task automatic t_tx_nine;
        nine_sel = 1'b1;
        for (int b = 1; b >= 0; b--) begin
            wr(ASP_OFF_TSC, 8'h64 | 8'(b));
            wr(ASP_OFF_TXB, 8'h81);
            exp_frame({2'b11, 8'h81} & {1'b1, 1'(b), 8'hff});
        end
        repeat (16) @(posedge clk_i);
        nine_sel = 1'b0;
    endtask : t_tx_nine

    task automatic t_abort;
        wr(ASP_OFF_TSC, 8'h24);
        wr(ASP_OFF_TXB, 8'hff);
        repeat (40) @(posedge clk_i);
        wr(ASP_OFF_TSC, 8'h04);
        `CHK(tx_oe_o, 1'b0)
        rd_chk(ASP_OFF_TSC, 8'h06);
        // clocked mode set: enabled transmitter must stay off the pin
        wr(ASP_OFF_TSC, 8'h34);
        `CHK(tx_oe_o, 1'b0)
        repeat (200) @(posedge clk_i);
        `CHK(peer.got_q.size(), 0)
    endtask : t_abort

    // divisor 1 at x16 gives 32 clocks a bit, divisor 0 at x64 gives 64
    task automatic t_baud;
        logic [7:0] brd[2] = '{8'h01, 8'h00};
        logic [7:0] tsc[2] = '{8'h24, 8'h20};
        int         clks[2] = '{32, 64};
        for (int i = 0; i < 2; i++) begin
            wr(ASP_OFF_BRD, brd[i]);
            wr(ASP_OFF_TSC, tsc[i]);
            peer.bit_clks = clks[i];
            wr(ASP_OFF_TXB, 8'h96);
            exp_frame(10'h296);
            repeat (64) @(posedge clk_i);
        end
        wr(ASP_OFF_TSC, 8'h04);
        wr(ASP_OFF_BRD, 8'h00);
        peer.bit_clks = 16;
    endtask : t_baud

    task automatic t_rx_overrun;
        wr(ASP_OFF_EVT, 8'h08);
        peer.send(9'h0ee, 1'b0, 1'b1);
        rd_chk(ASP_OFF_RSC, 8'h80);
        `CHK(rx_irq_o, 1'b0)
        wr(ASP_OFF_RSC, 8'h90);
        peer.send(9'h05a, 1'b0, 1'b1);
        peer.send(9'h0c3, 1'b0, 1'b1);
        peer.send(9'h011, 1'b0, 1'b1);
        `CHK(rx_irq_o, 1'b1)
        rd_chk(ASP_OFF_RSC, 8'h92);
        rd_chk(ASP_OFF_RXF, 8'h5a);
        rd_chk(ASP_OFF_RXF, 8'hc3);
        `CHK(rx_irq_o, 1'b0)
        peer.send(9'h077, 1'b0, 1'b1);
        `CHK(rx_irq_o, 1'b0)
        wr(ASP_OFF_RSC, 8'h80);
        wr(ASP_OFF_RSC, 8'h90);
        rd_chk(ASP_OFF_RSC, 8'h90);
    endtask : t_rx_overrun

    task automatic t_rx_nine;
        wr(ASP_OFF_RSC, 8'hd0);
        peer.send(9'h1a7, 1'b1, 1'b0);
        peer.send(9'h055, 1'b1, 1'b1);
        rd_chk(ASP_OFF_RSC, 8'hd5);
        rd_chk(ASP_OFF_RXF, 8'ha7);
        rd_chk(ASP_OFF_RSC, 8'hd0);
        rd_chk(ASP_OFF_RXF, 8'h55);
    endtask : t_rx_nine

    task automatic t_sleep;
        wr(ASP_OFF_RSC, 8'h90);
        sleep <= 1'b1;
        peer.send(9'h033, 1'b0, 1'b1);
        sleep <= 1'b0;
        repeat (16) @(posedge clk_i);
        `CHK(rx_irq_o, 1'b0)
        peer.send(9'h033, 1'b0, 1'b1);
        rd_chk(ASP_OFF_RXF, 8'h33);
    endtask : t_sleep

    task automatic tally_and_finish;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (20000) @(posedge clk_i);
        n_fail++;
        tally_and_finish();
    end

    initial begin
        clk_i = 1'b0;
        rstn_i = 1'b0;
        wb_cyc = 1'b0;
        wb_stb = 1'b0;
        wb_we = 1'b0;
        wb_sel = 4'h0;
        sel_v = 4'hf;
        wb_adr = 5'h00;
        wb_dat = 32'h00000000;
        sleep = 1'b0;
        nine_sel = 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        @(posedge clk_i);
        t_reset();
        t_tx_basic();
        t_tx_nine();
        t_abort();
        t_baud();
        t_rx_overrun();
        t_rx_nine();
        t_sleep();
        tally_and_finish();
    end
endmodule : tb_top
